// *** tb_i2c_slave_voltage_scale_ctrl.sv ***
// Testbench for the voltage scale serial slave
module tb_i2c_slave_voltage_scale_ctrl;
   timeunit 1ns;
   timeprecision 1ps;
   import vsc_pkg::*;
   logic        pclk = 1'h0, presetn = 1'h0, clk_en = 1'h1, psel = 1'h0, penable = 1'h0;
   logic        pwrite = 1'h0, interrupt_mode_pin = 1'h1, scale_activate_pin = 1'h0;
   logic        switch1_fault = 1'h0, pready, pslverr, sda_o, sda_oe, f_o, f_oe, scl, sda_h;
   logic [7:0]  paddr = 8'h0;
   logic [31:0] pwdata = 32'h0, prdata;
   logic [1:0]  second, third;
   int          n_errors, samples_checked, cyc;
   wire         sda_w = sda_h & ~sda_oe;
   always #5 pclk = ~pclk;
   vsc_top u_dut
   (
      .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe),
      .interrupt_mode_pin(interrupt_mode_pin), .scale_activate_pin(scale_activate_pin),
      .switch1_fault(switch1_fault), .switch1_fault_o(f_o), .switch1_fault_oe(f_oe),
      .second_step_down_converter_scale(second), .third_step_down_converter_scale(third)
   );
   vsc_host u_host (.scl(scl), .sda_h(sda_h), .sda(sda_w));
   // ****************************************************
   // Shared tasks
   // ****************************************************
   task give_verdict();
      $display("checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // Hang guard, well above the roughly 1100 cycles the run needs
   always @(posedge pclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         n_errors++;
         give_verdict();
      end
   end
   task check(input logic [7:0] seen, input logic [7:0] exp, input string what);
      samples_checked++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("mismatch at %0t: %s", $time, what);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [31:0] r);
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'h1;
      @(posedge pclk);
      while (pready !== 1'h1)
         @(posedge pclk);
      r = prdata;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      logic [31:0] r;
      apb(1'h0, a, 8'h0, r);
      check(r[7:0], exp, "register read");
   endtask
   task automatic wb(input logic [7:0] b, input logic exp);
      logic a;
      u_host.wbyte(b, a);
      check({7'h0, a}, {7'h0, exp}, "acknowledge");
   endtask
   task automatic settle();
      repeat (6) @(posedge pclk);
   endtask
   // ****************************************************
   // Scenarios
   // ****************************************************
   task automatic t_reset();
      logic [31:0] r;
      rd(APB_CTRL, 8'h01);
      rd(APB_ENABLE, 8'h00);
      rd(APB_TRIM, 8'h00);
      apb(1'h1, 8'h10, 8'hff, r);
      rd(8'h10, 8'h00);
      rd(APB_STATUS, 8'h06);
   endtask
   task automatic t_write();
      u_host.start();
      wb({GROUP_CODE, DEV_ADDR, 1'h0}, 1'h1);
      wb(IDX_ENABLE, 1'h1);
      wb(8'h01, 1'h1);
      wb(8'h0e, 1'h1);
      u_host.stop();
      rd(APB_ENABLE, 8'h01);
      rd(APB_TRIM, 8'h0e);
      check({6'h0, second}, 8'h02, "second scale");
      check({6'h0, third}, 8'h00, "third scale");
   endtask
   task automatic t_pin();
      logic [31:0] r;
      scale_activate_pin <= 1'h1;
      settle();
      check({6'h0, third}, 8'h03, "pin high");
      scale_activate_pin <= 1'h0;
      settle();
      check({6'h0, third}, 8'h00, "pin low");
      apb(1'h1, APB_TRIM, 8'h07, r);
      settle();
      check({6'h0, second}, 8'h03, "largest step");
      interrupt_mode_pin <= 1'h0;
      switch1_fault <= 1'h1;
      settle();
      check({6'h0, second}, 8'h00, "mode off");
      check({7'h0, f_oe}, 8'h01, "fault flag");
      check({7'h0, f_o}, 8'h00, "fault level");
      u_host.start();
      wb({GROUP_CODE, DEV_ADDR, 1'h0}, 1'h0);
      u_host.stop();
      @(posedge pclk);
      interrupt_mode_pin <= 1'h1;
      settle();
      check({7'h0, f_oe}, 8'h00, "fault flag off");
   endtask
   task automatic t_badaddr();
      u_host.start();
      wb({GROUP_CODE, 3'h1, 1'h0}, 1'h0);
      wb(IDX_TRIM, 1'h0);
      u_host.start();
      wb({4'hb, DEV_ADDR, 1'h0}, 1'h0);
      u_host.stop();
      rd(APB_TRIM, 8'h07);
   endtask
   task automatic t_read();
      logic [7:0] v;
      u_host.start();
      wb({GROUP_CODE, DEV_ADDR, 1'h0}, 1'h1);
      wb(IDX_ENABLE, 1'h1);
      u_host.start();
      wb({GROUP_CODE, DEV_ADDR, 1'h1}, 1'h1);
      u_host.rbyte(1'h0, v);
      check(v, 8'h01, "read first");
      u_host.rbyte(1'h1, v);
      check(v, 8'h07, "read next");
      u_host.stop();
   endtask
   initial
   begin
      repeat (20) @(posedge pclk);
      presetn <= 1'h1;
      repeat (3) @(posedge pclk);
      t_reset();
      t_write();
      t_pin();
      t_badaddr();
      t_read();
      give_verdict();
   end
endmodule
bind vsc_top vsc_chk u_chk
(
   .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
   .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_i(scl_i),
   .sda_o(sda_o), .sda_oe(sda_oe), .interrupt_mode_pin(interrupt_mode_pin),
   .switch1_fault(switch1_fault), .switch1_fault_oe(switch1_fault_oe),
   .second_step_down_converter_scale(second_step_down_converter_scale),
   .third_step_down_converter_scale(third_step_down_converter_scale)
);

// *** vsc_chk.sv ***
// Port checker for the voltage scale serial slave
module vsc_chk
(
   // Clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        clk_en,
   // APB
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // Serial and mode pins
   input wire logic        scl_i,
   input wire logic        sda_o,
   input wire logic        sda_oe,
   input wire logic        interrupt_mode_pin,
   input wire logic        switch1_fault,
   input wire logic        switch1_fault_oe,
   input wire logic [1:0]  second_step_down_converter_scale,
   input wire logic [1:0]  third_step_down_converter_scale
);
   import vsc_pkg::*;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ****************************************************
   // Assertions
   // ****************************************************
   apb_ready_a: assert property (psel && !penable |=> pready) else $error("pready low");
   apb_noerr_a: assert property (psel && penable |-> !pslverr) else $error("pslverr set");
   unmapped_zero_a: assert property (psel && !penable && paddr > APB_TRIM |=> prdata == 32'h0)
      else $error("unmapped read not zero");
   drive_low_a: assert property (sda_oe |-> !sda_o) else $error("data driven high");
   // Sync delay keeps changes well inside the low half of the serial clock
   oe_change_a: assert property ($changed(sda_oe) |-> !scl_i) else $error("data moved, clock high");
   ack_hold_a: assert property ($rose(sda_oe) |=> sda_oe[*5]) else $error("ack too short");
   mode_off_a: assert property ((!interrupt_mode_pin && clk_en)[*5] |->
      second_step_down_converter_scale == 2'h0 && third_step_down_converter_scale == 2'h0)
      else $error("scaling outside serial mode");
   fault_out_a: assert property ((switch1_fault && !interrupt_mode_pin)[*5] |-> switch1_fault_oe)
      else $error("fault flag not driven");
   fault_off_a: assert property (interrupt_mode_pin[*5] |-> !switch1_fault_oe)
      else $error("fault flag in serial mode");
   ack_seen_c: cover property ($rose(sda_oe));
   read_seen_c: cover property (psel && penable && paddr == APB_TRIM);
   mode_off_c: cover property ((!interrupt_mode_pin)[*5]);
endmodule

// *** vsc_host.sv ***
// Behavioural serial bus controller that owns the clock and drives data
module vsc_host
(
   // Serial lines
   output logic      scl,
   output logic      sda_h,
   input  wire logic sda
);
   timeunit 1ns;
   timeprecision 1ps;
   // Clock stands still high between frames
   initial
   begin
      scl = 1'h1;
      sda_h = 1'h1;
   end
   // Low half 50 ns, high half 30 ns; data moves only while low
   task automatic bitx(input logic b, output logic r);
      #10 sda_h = b;
      #40 scl = 1'h1;
      #15 r = sda;
      #15 scl = 1'h0;
   endtask
   task automatic start();
      #13 sda_h = 1'h1;
      #40 scl = 1'h1;
      #20 sda_h = 1'h0;
      #20 scl = 1'h0;
   endtask
   task automatic stop();
      #10 sda_h = 1'h0;
      #40 scl = 1'h1;
      #20 sda_h = 1'h1;
      #20;
   endtask
   task automatic wbyte(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
         bitx(b[i], r);
      bitx(1'h1, r);
      ack = ~r;
   endtask
   task automatic rbyte(input logic last, output logic [7:0] v);
      logic r;
      for (int i = 7; i >= 0; i--)
      begin
         bitx(1'h1, r);
         v[i] = r;
      end
      bitx(last, r);
   endtask
endmodule

// *** vsc_link.sv ***
// Serial slave engine: conditions, address match, acknowledge and byte transfer
//
// Our own choices: the placing of the registers and the APB interface to the registers.
module vsc_link
   import vsc_pkg::*;
(
   // Clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic clk_en,
   // Synchronised line levels and mode
   input  wire logic scl_s,
   input  wire logic sda_s,
   input  wire logic serial_mode,
   // Data line drive
   output logic      sda_oe,
   // Register access
   vsc_regif.engine  rif,
   // Status
   output logic      busy
);
   typedef struct packed
   {
      vsc_state_t st;
      vsc_state_t after_ack;
      logic       scl_d;
      logic       sda_d;
      logic [2:0] bit_cnt;
      logic [7:0] shift;
      logic [7:0] idx;
      logic       drive;
      logic       full;
      logic       we;
      logic [7:0] wdata;
   } vsc_link_t;

   vsc_link_t s_r;
   vsc_link_t s_nxt;
   logic      scl_rise;
   logic      scl_fall;
   logic      start_c;
   logic      stop_c;

   assign scl_rise = scl_s & ~s_r.scl_d;
   assign scl_fall = ~scl_s & s_r.scl_d;
   assign start_c  = scl_s & s_r.scl_d & s_r.sda_d & ~sda_s;
   assign stop_c   = scl_s & s_r.scl_d & ~s_r.sda_d & sda_s;

   always_comb
   begin
      s_nxt       = s_r;
      s_nxt.scl_d = scl_s;
      s_nxt.sda_d = sda_s;
      s_nxt.we    = 1'b0;
      if (!serial_mode || stop_c)
      begin
         s_nxt.st    = VSC_IDLE;
         s_nxt.drive = 1'b0;
      end
      else if (start_c)
      begin
         s_nxt.st      = VSC_ADDR;
         s_nxt.bit_cnt = 3'h0;
         s_nxt.full    = 1'b0;
         s_nxt.drive   = 1'b0;
      end
      else
      begin
         case (s_r.st)
            VSC_IDLE, VSC_SKIP:
            begin
               s_nxt.drive = 1'b0;
            end
            VSC_ADDR, VSC_INDEX, VSC_WDATA:
            begin
               // Sample on the rising clock edge; data is stable while clock is high
               if (scl_rise)
               begin
                  s_nxt.shift   = {s_r.shift[6:0], sda_s};
                  s_nxt.bit_cnt = s_r.bit_cnt + 3'h1;
                  s_nxt.full    = (s_r.bit_cnt == 3'h7);
               end
               // A byte is complete only after its eighth clock, not on the start edge
               if (scl_fall && s_r.full)
               begin
                  s_nxt.st    = VSC_ACK;
                  s_nxt.full  = 1'b0;
                  s_nxt.drive = 1'b1;
                  case (s_r.st)
                     VSC_ADDR:
                     begin
                        if (s_r.shift[7:4] == GROUP_CODE && s_r.shift[3:1] == DEV_ADDR)
                        begin
                           s_nxt.after_ack = s_r.shift[0] ?
                                             VSC_RDATA : VSC_INDEX;
                        end
                        else
                        begin
                           s_nxt.st    = VSC_SKIP;
                           s_nxt.drive = 1'b0;
                        end
                     end
                     VSC_INDEX:
                     begin
                        s_nxt.idx       = s_r.shift;
                        s_nxt.after_ack = VSC_WDATA;
                     end
                     default:
                     begin
                        s_nxt.we        = 1'b1;
                        s_nxt.wdata     = s_r.shift;
                        s_nxt.idx       = s_r.idx + 8'h01;
                        s_nxt.after_ack = VSC_WDATA;
                     end
                  endcase
               end
            end
            VSC_ACK:
            begin
               if (scl_fall)
               begin
                  s_nxt.st      = s_r.after_ack;
                  s_nxt.bit_cnt = 3'h0;
                  if (s_r.after_ack == VSC_RDATA)
                  begin
                     s_nxt.shift = rif.rdata;
                     s_nxt.drive = ~rif.rdata[7];
                     s_nxt.idx   = s_r.idx + 8'h01;
                  end
                  else
                  begin
                     s_nxt.drive = 1'b0;
                  end
               end
            end
            VSC_RDATA:
            begin
               if (scl_fall)
               begin
                  s_nxt.bit_cnt = s_r.bit_cnt + 3'h1;
                  if (s_r.bit_cnt == 3'h7)
                  begin
                     s_nxt.st    = VSC_RACK;
                     s_nxt.drive = 1'b0;
                  end
                  else
                  begin
                     s_nxt.shift = {s_r.shift[6:0], 1'b0};
                     s_nxt.drive = ~s_r.shift[6];
                  end
               end
            end
            VSC_RACK:
            begin
               // Host acknowledge low asks for another byte; a no-acknowledge ends it
               if (scl_rise)
               begin
                  s_nxt.st = sda_s ? VSC_SKIP : VSC_ACK;
               end
            end
            default:
            begin
               s_nxt.st = VSC_IDLE;
            end
         endcase
         if (s_r.st == VSC_RACK && scl_rise && !sda_s)
         begin
            s_nxt.after_ack = VSC_RDATA;
            s_nxt.drive     = 1'b0;
         end
      end
   end

   // The ack state is reused for read continuation so the host edge lines up
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s_r <= '{st: VSC_IDLE, after_ack: VSC_IDLE, scl_d: 1'b1, sda_d: 1'b1,
                  bit_cnt: 3'h0, shift: 8'h00, idx: 8'h00, drive: 1'b0,
                  full: 1'b0, we: 1'b0, wdata: 8'h00};
      end
      else if (clk_en)
      begin
         s_r <= s_nxt;
      end
   end

   assign sda_oe    = s_r.drive;
   assign rif.idx   = s_r.we ? s_r.idx - 8'h01 : s_r.idx;
   assign rif.wdata = s_r.wdata;
   assign rif.we    = s_r.we & clk_en;
   assign busy      = (s_r.st != VSC_IDLE);
endmodule

// *** vsc_pkg.sv ***
// Package with constants and types for the voltage scale serial slave
package vsc_pkg;
   // ****************************************************
   // Bus address and timing
   // ****************************************************
   localparam logic [3:0]  GROUP_CODE      = 4'h9;
   localparam logic [2:0]  DEV_ADDR        = 3'h0;
   localparam int          PCLK_MHZ        = 100;
   localparam int          LINK_KBPS_MAX   = 400;
   localparam int          LINK_BIT_CYCLES = (PCLK_MHZ * 1000) / LINK_KBPS_MAX;
   // ****************************************************
   // Serial register indexes
   // ****************************************************
   localparam int          NUM_REGS        = 4;
   localparam logic [7:0]  IDX_ENABLE      = 8'h00;
   localparam logic [7:0]  IDX_TRIM        = 8'h01;
   localparam logic [7:0]  IDX_SCRATCH0    = 8'h02;
   localparam logic [7:0]  IDX_SCRATCH1    = 8'h03;
   // Enable register fields
   localparam int          EN_ACT2_BIT     = 0;
   localparam int          EN_ACT3_BIT     = 1;
   // Trim register fields
   localparam int          TRIM_SEL2_LSB   = 0;
   localparam int          TRIM_SEL3_LSB   = 2;
   localparam logic [7:0]  REG_RESET       = 8'h00;
   // ****************************************************
   // APB register byte addresses
   // ****************************************************
   localparam logic [7:0]  APB_CTRL        = 8'h00;
   localparam logic [7:0]  APB_STATUS      = 8'h04;
   localparam logic [7:0]  APB_ENABLE      = 8'h08;
   localparam logic [7:0]  APB_TRIM        = 8'h0c;
   localparam int          CTRL_SERIAL_BIT = 0;
   localparam logic [31:0] CTRL_RESET      = 32'h0000_0001;
   // ****************************************************
   // Types
   // ****************************************************
   typedef enum logic [2:0]
   {
      VSC_IDLE  = 3'b000,
      VSC_ADDR  = 3'b001,
      VSC_INDEX = 3'b010,
      VSC_WDATA = 3'b011,
      VSC_RDATA = 3'b100,
      VSC_ACK   = 3'b101,
      VSC_RACK  = 3'b110,
      VSC_SKIP  = 3'b111
   } vsc_state_t;
endpackage

// *** vsc_regif.sv ***
// Interface carrying register writes between the serial engine and the register file
interface vsc_regif;
   logic [7:0] idx;
   logic [7:0] wdata;
   logic       we;
   logic [7:0] rdata;
   modport engine (output idx, output wdata, output we, input rdata);
   modport regs   (input idx, input wdata, input we, output rdata);
endinterface

// *** vsc_top.sv ***
// Top of the serial slave port with voltage scaling control and APB registers

// Overview of operation
// - Works at serial rates up to 400 kbit/s with oversampling clock.
// - Respond only when address starts with group code 1001.
// - Device address field after group code must be 000.
// - Eighth address bit low means write, high means read.
// - Start is data falling while serial clock is high.
// - Stop is data rising while serial clock is high; ends transfer.
// - Data changes only while serial clock is low, except conditions.
// - On write address match, acknowledge then expect register index byte.
// - Acknowledge each valid address, index and data byte.
// - Register index advances after each data byte in a transfer.
// - Two-bit select per converter gives 5, 10 or 15 percent reduction.
// - Reduction applies while activate pin high, withdrawn while low unless its enable register activate bit is set.
// - Enable register activate bits also apply the selected reductions.
// - Serial control only when interrupt-mode pin selects it.
// - Activate pin is voltage control only in serial mode.
module vsc_top
(
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        clk_en,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Serial pins
   input  wire logic        scl_i,
   input  wire logic        sda_i,
   output logic             sda_o,
   output logic             sda_oe,
   // Mode and scaling pins
   input  wire logic        interrupt_mode_pin,
   input  wire logic        scale_activate_pin,
   input  wire logic        switch1_fault,
   output logic             switch1_fault_o,
   output logic             switch1_fault_oe,
   // Converter reduction selects, zero means none
   output logic [1:0]       second_step_down_converter_scale,
   output logic [1:0]       third_step_down_converter_scale
);
   import vsc_pkg::*;
   // ****************************************************
   // State
   // ****************************************************
   typedef struct packed
   {
      logic [1:0] scl_sy;
      logic [1:0] sda_sy;
      logic [1:0] mode_sy;
      logic [1:0] act_sy;
      logic [1:0] flt_sy;
      logic [7:0] enable_reg;
      logic [7:0] trim_reg;
      logic [7:0] scratch0;
      logic [7:0] scratch1;
      logic       serial_en;
      logic [1:0] scale2;
      logic [1:0] scale3;
      logic [31:0] rdata;
   } vsc_top_t;

   vsc_top_t r_r;
   vsc_top_t r_nxt;
   vsc_regif rif ();
   logic     busy;
   logic     serial_mode;
   logic     apb_wr;
   logic     act2;
   logic     act3;

   // Mode pin sees the supply level as a logic high above threshold
   assign serial_mode = r_r.mode_sy[1] & r_r.serial_en;
   assign apb_wr      = psel & penable & pwrite;

   // ****************************************************
   // Serial engine
   // ****************************************************
   // Oversampling keeps many pclk cycles per bit at the fastest rate
   vsc_link u_link
   (
      .pclk        (pclk),
      .presetn     (presetn),
      .clk_en      (clk_en),
      .scl_s       (r_r.scl_sy[1]),
      .sda_s       (r_r.sda_sy[1]),
      .serial_mode (serial_mode),
      .sda_oe      (sda_oe),
      .rif         (rif.engine),
      .busy        (busy)
   );

   // Index beyond the map reads as zero and ignores writes
   always_comb
   begin
      case (rif.idx)
         IDX_ENABLE:   rif.rdata = r_r.enable_reg;
         IDX_TRIM:     rif.rdata = r_r.trim_reg;
         IDX_SCRATCH0: rif.rdata = r_r.scratch0;
         IDX_SCRATCH1: rif.rdata = r_r.scratch1;
         default:      rif.rdata = 8'h00;
      endcase
   end

   assign act2 = r_r.act_sy[1] | r_r.enable_reg[EN_ACT2_BIT];
   assign act3 = r_r.act_sy[1] | r_r.enable_reg[EN_ACT3_BIT];

   // ****************************************************
   // Next state
   // ****************************************************
   always_comb
   begin
      r_nxt         = r_r;
      r_nxt.scl_sy  = {r_r.scl_sy[0], scl_i};
      r_nxt.sda_sy  = {r_r.sda_sy[0], sda_i};
      r_nxt.mode_sy = {r_r.mode_sy[0], interrupt_mode_pin};
      r_nxt.act_sy  = {r_r.act_sy[0], scale_activate_pin};
      r_nxt.flt_sy  = {r_r.flt_sy[0], switch1_fault};
      if (rif.we)
      begin
         case (rif.idx)
            IDX_ENABLE:   r_nxt.enable_reg = rif.wdata;
            IDX_TRIM:     r_nxt.trim_reg   = rif.wdata;
            IDX_SCRATCH0: r_nxt.scratch0   = rif.wdata;
            IDX_SCRATCH1: r_nxt.scratch1   = rif.wdata;
            default:      r_nxt.scratch1   = r_r.scratch1;
         endcase
      end
      // APB write loses to a serial write in the same cycle, whichever register either one targets
      else if (apb_wr)
      begin
         case (paddr)
            APB_CTRL:   r_nxt.serial_en  = pwdata[CTRL_SERIAL_BIT];
            APB_ENABLE: r_nxt.enable_reg = pwdata[7:0];
            APB_TRIM:   r_nxt.trim_reg   = pwdata[7:0];
            default:    r_nxt.serial_en  = r_r.serial_en;
         endcase
      end
      // Without serial mode the trim settings are not applied at all
      r_nxt.scale2 = (serial_mode && act2) ?
                     r_r.trim_reg[TRIM_SEL2_LSB +: 2] : 2'h0;
      r_nxt.scale3 = (serial_mode && act3) ?
                     r_r.trim_reg[TRIM_SEL3_LSB +: 2] : 2'h0;
      case (paddr)
         APB_CTRL:   r_nxt.rdata = {31'h0, r_r.serial_en};
         APB_STATUS: r_nxt.rdata = {28'h0, r_r.act_sy[1], r_r.mode_sy[1], serial_mode, busy};
         APB_ENABLE: r_nxt.rdata = {24'h0, r_r.enable_reg};
         APB_TRIM:   r_nxt.rdata = {24'h0, r_r.trim_reg};
         default:    r_nxt.rdata = 32'h0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         r_r <= '{scl_sy: 2'h3, sda_sy: 2'h3, mode_sy: 2'h0, act_sy: 2'h0,
                  flt_sy: 2'h0,
                  enable_reg: REG_RESET, trim_reg: REG_RESET, scratch0: REG_RESET,
                  scratch1: REG_RESET, serial_en: CTRL_RESET[CTRL_SERIAL_BIT],
                  scale2: 2'h0, scale3: 2'h0, rdata: 32'h0};
      end
      else if (clk_en)
      begin
         r_r <= r_nxt;
      end
   end

   // ****************************************************
   // Outputs
   // ****************************************************
   // Read data is registered in setup, so access completes in one cycle
   assign prdata                           = r_r.rdata;
   assign pready                           = 1'b1;
   assign pslverr                          = 1'b0;
   assign sda_o                            = 1'b0;
   // While the interrupt-mode pin is low the switch1_fault input is driven out low as the switch fault flag
   assign switch1_fault_o                  = 1'b0;
   assign switch1_fault_oe                 = ~r_r.mode_sy[1] & r_r.flt_sy[1];
   assign second_step_down_converter_scale = r_r.scale2;
   assign third_step_down_converter_scale  = r_r.scale3;
endmodule
